// ---- rtl/pcs_pkg.sv ----
// Package for the program counter and return stack unit
package pcs_pkg;

   localparam int PC_W      = 21;
   localparam int PTR_W     = 5;
   localparam int DEPTH     = 31;
   localparam int DATA_W    = 32;
   localparam int ADDR_W    = 12;

   localparam logic [PC_W-1:0]  RESET_VECTOR = 21'h000000;
   localparam logic [PC_W-1:0]  HI_VECTOR    = 21'h000008;
   localparam logic [PC_W-1:0]  LO_VECTOR    = 21'h000018;
   localparam logic [PC_W-1:0]  PC_STEP      = 21'h000002;
   localparam logic [PTR_W-1:0] PTR_TOP      = 5'h1F;
   localparam logic [PTR_W-1:0] PTR_ZERO     = 5'h00;
   localparam logic [PTR_W-1:0] PTR_ONE      = 5'h01;
   localparam logic [PC_W-1:0]  PROG_LIMIT   = 21'h010000;

   localparam logic [ADDR_W-1:0] OFS_PC_LOW     = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_HIGH_LATCH = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_UPPER_LATCH= 12'h008;
   localparam logic [ADDR_W-1:0] OFS_TOS_LOW    = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_TOS_HIGH   = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_TOS_UPPER  = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_STACK_PTR  = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_CONFIG     = 12'h01C;
   localparam logic [ADDR_W-1:0] OFS_PC_FULL    = 12'h020;

   localparam int FULL_BIT  = 7;
   localparam int UNF_BIT   = 6;
   localparam int CFG_STVR  = 0;
   localparam logic CFG_RESET_VAL = 1'b1;

   typedef enum logic [3:0] {
      PCS_OP_NONE,
      PCS_OP_STEP,
      PCS_OP_JUMP,
      PCS_OP_CALL,
      PCS_OP_RETURN,
      PCS_OP_IRQ,
      PCS_OP_RETURN_FROM_INTERRUPT,
      PCS_OP_PUSH,
      PCS_OP_POP
   } pcs_op_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working;
      logic [7:0] bank;
   } pcs_ctx_t;

   typedef struct packed {
      pcs_op_t         op;
      logic [PC_W-1:0] target;
      logic            fast;
      logic            high_prio;
      pcs_ctx_t        ctx;
   } pcs_cmd_t;

endpackage

// ---- rtl/pcs_unit.sv ----
// Program counter, return address stack and fast shadow stack
// Notes on behaviour
// - Program counter is 21 bits wide
// - Fetches beyond implemented memory return zero
// - Reset to 0000h; interrupts vector 0008h/0018h
// - Only low byte directly accessible; OFS_PC_FULL also reads the whole PC
// - Low byte write/read moves latches
// - Bit zero fixed; step is two
// - Jumps and calls ignore latches
// - 31 entries of 21 bits, 5-bit pointer
// - Calls/interrupts push, returns pop; latches untouched
// - Push increments first; pop reads then decrements
// - Every reset clears pointer; zero has no entry; por_in alone leaves the pointer
// - Top entry and pointer are software accessible
// - 31 pushes set full flag
// - With enable, 31st push stores, flags, resets
// - Without enable, pointer sticks at 31
// - Pop at zero loads zero, sets underflow
// - Stack errors reset only when enabled
// - Explicit push stores PC, pop discards top
// - Pointer register layout and reset zero
// - Interrupt loads shadow; fast return restores
// - High priority interrupt overwrites shadow
// - Fast call saves, fast return restores
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module pcs_unit
   import pcs_pkg::*;
(
   // Clock and resets
   input  wire logic                        sys_clk_in,
   input  wire logic                        sys_rst_in,
   input  wire logic                        por_in,
   // Sequencer command
   input  wire pcs_pkg::pcs_cmd_t           cmd_in,
   input  wire logic [pcs_pkg::PC_W-1:0]    fetch_data_in,
   // APB slave
   input  wire logic                        psel_in,
   input  wire logic                        penable_in,
   input  wire logic                        pwrite_in,
   input  wire logic [pcs_pkg::ADDR_W-1:0]  paddr_in,
   input  wire logic [pcs_pkg::DATA_W-1:0]  pwdata_in,
   output logic [pcs_pkg::DATA_W-1:0]       prdata_out,
   output logic                             pready_out,
   output logic                             pslverr_out,
   // Core side
   output logic [pcs_pkg::PC_W-1:0]         pc_out,
   output logic                             fetch_valid_out,
   output pcs_pkg::pcs_ctx_t                ctx_restore_out,
   output logic                             ctx_restore_valid_out,
   output logic                             device_reset_out
);
   import pcs_pkg::*;

   logic [PC_W-1:0]  pc_reg;
   logic [PC_W-1:0]  pc_next;
   logic [7:0]       high_latch_reg;
   logic [4:0]       upper_latch_reg;
   logic [PC_W-1:0]  stack_reg [1:DEPTH];
   logic [PTR_W-1:0] ptr_reg;
   logic [PTR_W-1:0] ptr_next;
   logic             full_reg;
   logic             unf_reg;
   logic             cfg_stvr_reg;
   pcs_ctx_t         shadow_reg;
   logic             err_reset_reg;
   logic             fetch_valid_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic             pready_reg;
   logic             pslverr_reg;
   pcs_ctx_t         ctx_out_reg;
   logic             ctx_valid_reg;

   logic             wr_acc;
   logic             rd_acc;
   logic             is_push;
   logic             is_pop;
   logic             push_full;
   logic             push_err;
   logic             pop_err;
   logic [PC_W-1:0]  ret_addr;
   logic [PC_W-1:0]  tos_val;
   logic             any_reset;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
      hit = (a == o);
   endfunction

   function automatic logic known(input logic [ADDR_W-1:0] a);
      known = hit(a, OFS_PC_LOW) || hit(a, OFS_HIGH_LATCH) || hit(a, OFS_UPPER_LATCH) ||
              hit(a, OFS_TOS_LOW) || hit(a, OFS_TOS_HIGH) || hit(a, OFS_TOS_UPPER) ||
              hit(a, OFS_STACK_PTR) || hit(a, OFS_CONFIG) || hit(a, OFS_PC_FULL);
   endfunction

   // APB access: setup, then access phase with pready high one cycle after penable
   assign wr_acc = psel_in && penable_in && pwrite_in && !pready_reg;
   assign rd_acc = psel_in && penable_in && !pwrite_in && !pready_reg;

   assign is_push  = (cmd_in.op == PCS_OP_CALL) || (cmd_in.op == PCS_OP_IRQ) ||
                     (cmd_in.op == PCS_OP_PUSH);
   assign is_pop   = (cmd_in.op == PCS_OP_RETURN) || (cmd_in.op == PCS_OP_RETURN_FROM_INTERRUPT) ||
                     (cmd_in.op == PCS_OP_POP);
   assign push_full = is_push && (ptr_reg >= PTR_TOP - PTR_ONE);
   assign push_err  = push_full && cfg_stvr_reg;
   assign pop_err   = is_pop && (ptr_reg == PTR_ZERO) && cfg_stvr_reg;
   assign any_reset = sys_rst_in || err_reset_reg;
   assign tos_val   = (ptr_reg == PTR_ZERO) ? RESET_VECTOR : stack_reg[ptr_reg];
   // Explicit push stores the current PC, calls store the following address
   assign ret_addr  = (cmd_in.op == PCS_OP_PUSH) ? pc_reg : pc_reg + PC_STEP;

   // Program counter update
   always_comb begin
      pc_next = pc_reg;
      if (wr_acc && hit(paddr_in, OFS_PC_LOW)) begin
         pc_next = {upper_latch_reg, high_latch_reg, pwdata_in[7:1], 1'b0};
      end else begin
         unique case (cmd_in.op)
            PCS_OP_STEP:   pc_next = pc_reg + PC_STEP;
            PCS_OP_JUMP,
            PCS_OP_CALL:   pc_next = {cmd_in.target[PC_W-1:1], 1'b0};
            PCS_OP_IRQ:    pc_next = cmd_in.high_prio ? HI_VECTOR : LO_VECTOR;
            PCS_OP_RETURN,
            PCS_OP_RETURN_FROM_INTERRUPT: pc_next = {tos_val[PC_W-1:1], 1'b0};
            PCS_OP_NONE,
            PCS_OP_PUSH,
            PCS_OP_POP:    pc_next = pc_reg;
            default:       pc_next = pc_reg;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (any_reset || push_err || pop_err) begin
         pc_reg <= RESET_VECTOR;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Latches change only on reset, low byte read or software write
   always_ff @(posedge sys_clk_in) begin
      if (any_reset) begin
         high_latch_reg  <= 8'h00;
         upper_latch_reg <= 5'h00;
      end else if (rd_acc && hit(paddr_in, OFS_PC_LOW)) begin
         high_latch_reg  <= pc_reg[15:8];
         upper_latch_reg <= pc_reg[20:16];
      end else if (wr_acc && hit(paddr_in, OFS_HIGH_LATCH)) begin
         high_latch_reg  <= pwdata_in[7:0];
      end else if (wr_acc && hit(paddr_in, OFS_UPPER_LATCH)) begin
         upper_latch_reg <= pwdata_in[4:0];
      end
   end

   // Pointer movement
   always_comb begin
      ptr_next = ptr_reg;
      if (wr_acc && hit(paddr_in, OFS_STACK_PTR)) begin
         ptr_next = pwdata_in[PTR_W-1:0];
      end else if (is_push && ptr_reg != PTR_TOP) begin
         ptr_next = ptr_reg + PTR_ONE;
      end else if (is_pop && ptr_reg != PTR_ZERO) begin
         ptr_next = ptr_reg - PTR_ONE;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (any_reset) begin
         ptr_reg <= PTR_ZERO;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   // Stack storage, entry zero has no storage
   generate
      for (genvar i = 1; i <= DEPTH; i++) begin : g_entry
         always_ff @(posedge sys_clk_in) begin
            if (is_push && !any_reset && ptr_reg != PTR_TOP &&
                ptr_reg + PTR_ONE == PTR_W'(i)) begin
               stack_reg[i] <= ret_addr;
            end else if (wr_acc && ptr_reg == PTR_W'(i)) begin
               if (hit(paddr_in, OFS_TOS_LOW))   stack_reg[i][7:0]   <= pwdata_in[7:0];
               if (hit(paddr_in, OFS_TOS_HIGH))  stack_reg[i][15:8]  <= pwdata_in[7:0];
               if (hit(paddr_in, OFS_TOS_UPPER)) stack_reg[i][20:16] <= pwdata_in[4:0];
            end
         end
      end
   endgenerate

   // Sticky flags: hardware set wins over software clear; only POR clears otherwise
   always_ff @(posedge sys_clk_in) begin
      if (por_in) begin
         full_reg <= 1'b0;
         unf_reg  <= 1'b0;
      end else begin
         if (push_full && !sys_rst_in)
            full_reg <= 1'b1;
         else if (wr_acc && hit(paddr_in, OFS_STACK_PTR) && !pwdata_in[FULL_BIT])
            full_reg <= 1'b0;
         if (is_pop && ptr_reg == PTR_ZERO && !sys_rst_in)
            unf_reg <= 1'b1;
         else if (wr_acc && hit(paddr_in, OFS_STACK_PTR) && !pwdata_in[UNF_BIT])
            unf_reg <= 1'b0;
      end
   end

   // Stack error reset request, one cycle
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         err_reset_reg <= 1'b0;
      end else begin
         err_reset_reg <= push_err || pop_err;
      end
   end

   // Configuration: stack error reset enable, set at power-on
   always_ff @(posedge sys_clk_in) begin
      if (por_in) begin
         cfg_stvr_reg <= CFG_RESET_VAL;
      end else if (wr_acc && hit(paddr_in, OFS_CONFIG)) begin
         cfg_stvr_reg <= pwdata_in[CFG_STVR];
      end
   end

   // Shadow stack
   always_ff @(posedge sys_clk_in) begin
      if (any_reset) begin
         shadow_reg <= '0;
      end else if (cmd_in.op == PCS_OP_IRQ ||
                   (cmd_in.op == PCS_OP_CALL && cmd_in.fast)) begin
         shadow_reg <= cmd_in.ctx;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (any_reset) begin
         ctx_out_reg   <= '0;
         ctx_valid_reg <= 1'b0;
      end else begin
         ctx_out_reg   <= shadow_reg;
         ctx_valid_reg <= cmd_in.fast &&
                          (cmd_in.op == PCS_OP_RETURN_FROM_INTERRUPT || cmd_in.op == PCS_OP_RETURN);
      end
   end

   // Fetch gate: beyond implemented memory fetches as zero
   always_ff @(posedge sys_clk_in) begin
      if (any_reset) begin
         fetch_valid_reg <= 1'b0;
      end else begin
         fetch_valid_reg <= (pc_next < PROG_LIMIT);
      end
   end

   // APB read data and completion
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         prdata_reg  <= '0;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= psel_in && penable_in && !pready_reg;
         pslverr_reg <= psel_in && penable_in && !pready_reg && !known(paddr_in);
         prdata_reg  <= '0;
         if (rd_acc) begin
            if (hit(paddr_in, OFS_PC_LOW))      prdata_reg[7:0] <= pc_reg[7:0];
            if (hit(paddr_in, OFS_HIGH_LATCH))  prdata_reg[7:0] <= high_latch_reg;
            if (hit(paddr_in, OFS_UPPER_LATCH)) prdata_reg[4:0] <= upper_latch_reg;
            if (hit(paddr_in, OFS_TOS_LOW))     prdata_reg[7:0] <= tos_val[7:0];
            if (hit(paddr_in, OFS_TOS_HIGH))    prdata_reg[7:0] <= tos_val[15:8];
            if (hit(paddr_in, OFS_TOS_UPPER))   prdata_reg[4:0] <= tos_val[20:16];
            if (hit(paddr_in, OFS_STACK_PTR))
               prdata_reg[7:0] <= {full_reg, unf_reg, 1'b0, ptr_reg};
            if (hit(paddr_in, OFS_CONFIG))      prdata_reg[CFG_STVR] <= cfg_stvr_reg;
            if (hit(paddr_in, OFS_PC_FULL))     prdata_reg[PC_W-1:0] <= pc_reg;
         end
      end
   end

   assign prdata_out            = prdata_reg;
   assign pready_out            = pready_reg;
   assign pslverr_out           = pslverr_reg;
   assign pc_out                = pc_reg;
   assign fetch_valid_out       = fetch_valid_reg;
   assign ctx_restore_out       = ctx_out_reg;
   assign ctx_restore_valid_out = ctx_valid_reg;
   assign device_reset_out      = err_reset_reg;

   // Checks
   chk_pc_aligned: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      pc_reg[0] == 1'b0) else $error("pc bit zero set");
   chk_step_two: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (cmd_in.op == PCS_OP_STEP && !wr_acc && !err_reset_reg) |=> pc_reg == $past(pc_reg) + PC_STEP)
      else $error("step not two");
   chk_irq_vector: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (cmd_in.op == PCS_OP_IRQ && !wr_acc && !push_err && !err_reset_reg)
      |=> (pc_reg == HI_VECTOR || pc_reg == LO_VECTOR)) else $error("bad vector");
   chk_ptr_reset: assert property (@(posedge sys_clk_in)
      sys_rst_in |=> ptr_reg == PTR_ZERO) else $error("pointer not cleared");
   chk_ptr_bound: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (is_push && ptr_reg == PTR_TOP && !wr_acc && !err_reset_reg) |=> ptr_reg == PTR_TOP)
      else $error("pointer passed top");
   chk_full_set: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in || por_in)
      push_full |=> full_reg) else $error("full flag missing");
   chk_unf_set: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in || por_in)
      (is_pop && ptr_reg == PTR_ZERO) |=> unf_reg && ptr_reg == PTR_ZERO)
      else $error("underflow flag missing");
   chk_err_reset: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (push_err || pop_err) |=> device_reset_out ##1 (ptr_reg == PTR_ZERO && pc_reg == RESET_VECTOR))
      else $error("stack error reset missing");
   chk_latch_keep: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (is_push && !psel_in) |=> $stable(high_latch_reg) && $stable(upper_latch_reg))
      else $error("latch changed on call");

endmodule
`default_nettype wire

// ---- test/pcs_seq_model.sv ----
// Sequencer model that hands the unit one command at a time
`timescale 1ns/1ns
`default_nettype none
module pcs_seq_model (
   // Clock
   input  wire logic           sys_clk_in,
   // Command to the unit
   output var pcs_pkg::pcs_cmd_t cmd_out
);
   import pcs_pkg::*;

   initial cmd_out = '0;

   // A command stands for exactly one edge, then the line goes idle
   task automatic issue(input pcs_op_t op, input logic [PC_W-1:0] tgt,
                        input logic fast, input logic hp, input pcs_ctx_t ctx);
      @(posedge sys_clk_in);
      cmd_out <= '{op: op, target: tgt, fast: fast, high_prio: hp, ctx: ctx};
      @(posedge sys_clk_in);
      cmd_out <= '0;
   endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the program counter and return stack unit
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pcs_pkg::*;
   logic              sys_clk_in = 1'b0;
   logic              sys_rst_in = 1'b1;
   logic              por_in     = 1'b1;
   logic              psel_in    = 1'b0;
   logic              penable_in = 1'b0;
   logic              pwrite_in  = 1'b0;
   logic [ADDR_W-1:0] paddr_in   = '0;
   logic [DATA_W-1:0] pwdata_in  = '0;
   logic [DATA_W-1:0] prdata_out;
   logic              pready_out;
   logic              pslverr_out;
   logic [PC_W-1:0]   pc_out;
   logic              fetch_valid_out;
   pcs_ctx_t          ctx_restore_out;
   logic              ctx_restore_valid_out;
   logic              device_reset_out;
   pcs_cmd_t          cmd;
   int                fail_count = 0;
   int                checked = 0;
   int                pc = 0;
   int                ptr = 0;
   int                full = 0;
   int                unf = 0;
   int                cfg = 1;
   int                seed;
   int                stack[32];
   logic [23:0]       shadow;
   logic [31:0]       rd;
   logic              err;

   always #50 sys_clk_in = ~sys_clk_in;

   pcs_seq_model seq (.sys_clk_in(sys_clk_in), .cmd_out(cmd));

   pcs_unit dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .por_in(por_in),
      .cmd_in(cmd), .fetch_data_in(21'h0), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .pc_out(pc_out), .fetch_valid_out(fetch_valid_out),
      .ctx_restore_out(ctx_restore_out), .ctx_restore_valid_out(ctx_restore_valid_out),
      .device_reset_out(device_reset_out));

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      n = 0;
      // Registered answer: values read here are those sampled at this rising edge
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (pready_out !== 1'b1) begin
         fail_count++;
         print_verdict();
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic chk_ptr();
      apb(1'b0, OFS_STACK_PTR, 32'h0);
      check("stack_ptr", rd, {24'h0, full[0], unf[0], 1'b0, ptr[4:0]});
   endtask

   task automatic chk_top();
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, OFS_TOS_LOW + ADDR_W'(4 * i), 32'h0);
         check("top_entry", rd, (stack[ptr] >> (8 * i)) & (i == 2 ? 32'h1F : 32'hFF));
      end
   endtask

   // Drives one command and updates the reference model alongside
   task automatic run(input pcs_op_t op, input int tgt, input logic fast, input logic hp);
      logic [23:0] c;
      logic        rst_exp;
      logic        rv_exp;
      logic        rst_seen;
      logic        rv_seen;
      c = 24'($urandom);
      rst_exp = 1'b0;
      rv_exp = 1'b0;
      rst_seen = 1'b0;
      rv_seen = 1'b0;
      seq.issue(op, tgt[PC_W-1:0], fast, hp, c);
      if (op == PCS_OP_STEP) pc = pc + 2;
      if (op == PCS_OP_JUMP) pc = tgt & 32'h1FFFFE;
      if (op inside {PCS_OP_CALL, PCS_OP_IRQ, PCS_OP_PUSH}) begin
         if (ptr < DEPTH) begin
            ptr++;
            // Calls and interrupts save the following instruction, push saves the current one
            stack[ptr] = (op == PCS_OP_PUSH) ? pc : ((pc + 2) & 32'h1FFFFF);
         end
         if (ptr == DEPTH) full = 1;
         if (op == PCS_OP_CALL) pc = tgt;
         if (op == PCS_OP_IRQ) pc = hp ? HI_VECTOR : LO_VECTOR;
         if (fast || op == PCS_OP_IRQ) shadow = c;
         rst_exp = (ptr == DEPTH) && cfg;
      end
      if (op inside {PCS_OP_RETURN, PCS_OP_RETURN_FROM_INTERRUPT, PCS_OP_POP}) begin
         rv_exp = fast && op != PCS_OP_POP;
         rst_exp = (ptr == 0) && cfg;
         if (ptr == 0) unf = 1;
         if (op != PCS_OP_POP) pc = (ptr == 0) ? 0 : stack[ptr];
         if (ptr > 0) ptr--;
      end
      if (rst_exp) begin
         pc = 0;
         ptr = 0;
      end
      repeat (3) begin
         @(negedge sys_clk_in);
         rst_seen |= device_reset_out;
         rv_seen |= ctx_restore_valid_out;
      end
      check("device_reset", rst_seen, rst_exp);
      check("restore_valid", rv_seen, rv_exp);
      if (rv_exp) check("restore_ctx", ctx_restore_out, shadow);
      check("pc", pc_out, pc[PC_W-1:0]);
      check("fetch_valid", fetch_valid_out, pc < PROG_LIMIT);
   endtask

   initial begin
      seed = $urandom(32'h5DEC);
      repeat (6) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      por_in <= 1'b0;
      @(negedge sys_clk_in);
      check("reset_pc", pc_out, RESET_VECTOR);
      chk_ptr();
      apb(1'b0, OFS_CONFIG, 32'h0);
      check("config", rd, 32'h1);
      apb(1'b0, 12'hFFC, 32'h0);
      check("unmapped_err", err, 1'b1);
      $display("test reset done");
      run(PCS_OP_STEP, 0, 1'b0, 1'b0);
      run(PCS_OP_JUMP, 32'h10001, 1'b0, 1'b0);
      run(PCS_OP_JUMP, 32'hFFFE, 1'b0, 1'b0);
      run(PCS_OP_STEP, 0, 1'b0, 1'b0);
      $display("test fetch done");
      apb(1'b1, OFS_HIGH_LATCH, 32'h34);
      apb(1'b1, OFS_UPPER_LATCH, 32'h01);
      run(PCS_OP_JUMP, 32'h2000, 1'b0, 1'b0);
      apb(1'b1, OFS_PC_LOW, 32'h57);
      @(negedge sys_clk_in);
      pc = 32'h13456;
      check("pc_low_write", pc_out, pc[PC_W-1:0]);
      run(PCS_OP_JUMP, 32'h0ABCDE, 1'b0, 1'b0);
      apb(1'b0, OFS_PC_LOW, 32'h0);
      check("pc_low_read", rd, 32'hDE);
      apb(1'b0, OFS_HIGH_LATCH, 32'h0);
      check("high_latch", rd, 32'hBC);
      apb(1'b0, OFS_UPPER_LATCH, 32'h0);
      check("upper_latch", rd, 32'h0A);
      $display("test latches done");
      apb(1'b1, OFS_CONFIG, 32'h0);
      cfg = 0;
      for (int k = 0; k < 32; k++) begin
         run(PCS_OP_CALL, $urandom & 32'h1FFFFE, 1'b0, 1'b0);
         chk_top();
      end
      chk_ptr();
      apb(1'b1, OFS_TOS_LOW, 32'h40);
      stack[ptr] = (stack[ptr] & 32'h1FFF00) | 32'h40;
      run(PCS_OP_RETURN, 0, 1'b0, 1'b0);
      apb(1'b1, OFS_STACK_PTR, 32'hC3);
      ptr = 3;
      chk_ptr();
      apb(1'b1, OFS_STACK_PTR, 32'h03);
      full = 0;
      chk_ptr();
      run(PCS_OP_PUSH, 0, 1'b0, 1'b0);
      chk_top();
      run(PCS_OP_POP, 0, 1'b0, 1'b0);
      chk_top();
      repeat (4) run(PCS_OP_RETURN, 0, 1'b0, 1'b0);
      chk_ptr();
      $display("test stack done");
      run(PCS_OP_IRQ, 0, 1'b0, 1'b0);
      run(PCS_OP_IRQ, 0, 1'b0, 1'b1);
      run(PCS_OP_RETURN_FROM_INTERRUPT, 0, 1'b1, 1'b0);
      run(PCS_OP_RETURN_FROM_INTERRUPT, 0, 1'b0, 1'b0);
      run(PCS_OP_CALL, 32'h1234, 1'b1, 1'b0);
      run(PCS_OP_RETURN, 0, 1'b1, 1'b0);
      $display("test shadow done");
      apb(1'b1, OFS_CONFIG, 32'h1);
      cfg = 1;
      apb(1'b1, OFS_STACK_PTR, 32'h0);
      unf = 0;
      run(PCS_OP_RETURN, 0, 1'b0, 1'b0);
      repeat (31) run(PCS_OP_CALL, $urandom & 32'h0FFFE, 1'b0, 1'b0);
      chk_ptr();
      @(posedge sys_clk_in);
      sys_rst_in <= 1'b1;
      @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      chk_ptr();
      $display("test error reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
